// ===== include/muxp_pkg.sv
// shared types and constants for the multiplexed host register port
// assumes one 10 MHz clock; host pins are asynchronous to it
package muxp_pkg;
	// ==============================================================
	// widths and timing
	// ==============================================================
	// width of the shared address/data lines
	localparam int AD_W = 8;
	// system clock period in ns
	localparam int CLK_PERIOD_NS = 100;
	// pin-to-logic latency of the input synchroniser, in clocks
	localparam int SYNC_LAT = 2;

	// ==============================================================
	// pin bundle as seen after synchronisation
	// ==============================================================
	typedef struct packed {
		logic cs_n; // chip select, active low
		logic address_latch_n; // address strobe, active low
		logic read_strobe_n; // read strobe, active low
		logic write_strobe_n; // write strobe, active low
		logic [AD_W-1:0] ad; // shared address/data lines
	} muxp_pins_t;

	// width of the synchronised bundle
	localparam int PINS_W = $bits(muxp_pins_t);

	// idle pin levels, used as synchroniser reset value
	localparam muxp_pins_t PINS_IDLE = '{
		cs_n: 1'h1,
		address_latch_n: 1'h1,
		read_strobe_n: 1'h1,
		write_strobe_n: 1'h1,
		ad: 8'h00
	};

	// reset value of the held address and data bytes
	localparam logic [AD_W-1:0] BYTE_RST = 8'h00;

	// access phase of the port
	typedef enum logic [1:0] {
		MUXP_IDLE,
		MUXP_ADDR,
		MUXP_DATA
	} muxp_phase_t;
endpackage

// ===== verilog/muxp_sync.sv
// two-stage synchroniser for a bundle of asynchronous pins
// assumes each bit is independently sampled; multi-bit skew is absorbed by the caller
module muxp_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	// first stage, read only by the second stage
	logic [W-1:0] meta;

	// ==============================================================
	// double flop
	// ==============================================================
	// reset to idle levels so no false edge is seen after reset
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			meta <= RST_VAL;
			sync_out <= RST_VAL;
		end
		else
		begin
			meta <= async_in;
			sync_out <= meta;
		end
	end
endmodule

// ===== verilog/muxp_port.sv
// multiplexed 8-bit host register port: latches an address, then moves one or more bytes at that address
// assumes host strobes are slow against clk (several clocks per phase) and that
// register storage sits outside, answering rd_req with rd_data on the same clock
module muxp_port (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic cs_n,
	input wire logic address_latch_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic [muxp_pkg::AD_W-1:0] ad_in,
	output logic [muxp_pkg::AD_W-1:0] ad_out,
	output logic ad_oe,
	output logic [muxp_pkg::AD_W-1:0] reg_addr,
	output logic rd_req,
	input wire logic [muxp_pkg::AD_W-1:0] rd_data,
	output logic wr_start,
	output logic wr_req,
	output logic [muxp_pkg::AD_W-1:0] wr_data,
	output logic data_phase
);
	// ==============================================================
	// input synchronisation
	// ==============================================================
	// raw pins gathered into one bundle
	muxp_pkg::muxp_pins_t raw_pins;
	// bundle after two flops
	muxp_pkg::muxp_pins_t s;
	// bundle one clock older, for edge detection
	muxp_pkg::muxp_pins_t p;
	// current access phase
	muxp_pkg::muxp_phase_t phase;

	// flat copies so $past sees plain signals
	logic s_cs_n;
	logic s_rd_n;
	logic s_wr_n;
	logic [muxp_pkg::AD_W-1:0] s_ad;

	assign raw_pins = '{
		cs_n: cs_n,
		address_latch_n: address_latch_n,
		read_strobe_n: read_strobe_n,
		write_strobe_n: write_strobe_n,
		ad: ad_in
	};
	assign s_cs_n = s.cs_n;
	assign s_rd_n = s.read_strobe_n;
	assign s_wr_n = s.write_strobe_n;
	assign s_ad = s.ad;

	// strobes and data share one synchroniser so they keep their alignment
	muxp_sync #(
		.W(muxp_pkg::PINS_W),
		.RST_VAL(muxp_pkg::PINS_IDLE)
	) i_muxp_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.async_in(raw_pins),
		.sync_out(s)
	);

	// previous sample of the synchronised bundle
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			p <= muxp_pkg::PINS_IDLE;
		else
			p <= s;
	end

	// ==============================================================
	// edge decode
	// ==============================================================
	// latch strobe going high closes the address phase
	logic latch_rise;
	// read strobe falling edge
	logic rd_fall;
	// write strobe edges
	logic wr_fall;
	logic wr_rise;
	// chip select is asserted now
	logic sel;

	assign sel = !s.cs_n;
	assign latch_rise = !p.address_latch_n && s.address_latch_n;
	assign rd_fall = p.read_strobe_n && !s.read_strobe_n;
	assign wr_fall = p.write_strobe_n && !s.write_strobe_n;
	assign wr_rise = !p.write_strobe_n && s.write_strobe_n;

	// ==============================================================
	// phase tracking
	// ==============================================================
	// dropping chip select always ends the access, whatever the strobes do
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			phase <= muxp_pkg::MUXP_IDLE;
		else if (!sel)
			phase <= muxp_pkg::MUXP_IDLE;
		else if (!s.address_latch_n)
			phase <= muxp_pkg::MUXP_ADDR;
		else if (latch_rise)
			phase <= muxp_pkg::MUXP_DATA;
	end

	// data phase flag for the register side
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			data_phase <= 1'h0;
		else
			data_phase <= sel && (phase == muxp_pkg::MUXP_DATA || latch_rise);
	end

	// ==============================================================
	// address latch
	// ==============================================================
	// address holds until the next latch edge, so back-to-back data
	// accesses without a new address reuse it
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			reg_addr <= muxp_pkg::BYTE_RST;
		else if (sel && latch_rise)
			reg_addr <= s.ad;
	end

	// ==============================================================
	// read path
	// ==============================================================
	// one-clock request to the register side on the read strobe fall
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			rd_req <= 1'h0;
		else
			rd_req <= sel && rd_fall && phase == muxp_pkg::MUXP_DATA;
	end

	// fetched byte is held until the next read, not cleared on strobe rise
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			ad_out <= muxp_pkg::BYTE_RST;
		else if (rd_req)
			ad_out <= rd_data;
	end

	// enable is the slowest path to release: it follows the synchronised
	// strobe, so the pad keeps driving about three clocks past the rise
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			ad_oe <= 1'h0;
		else
			ad_oe <= sel && !s.read_strobe_n && phase == muxp_pkg::MUXP_DATA;
	end

	// ==============================================================
	// write path
	// ==============================================================
	// strobe fall only announces the write; data is taken at the rise
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			wr_start <= 1'h0;
		else
			wr_start <= sel && wr_fall && phase == muxp_pkg::MUXP_DATA;
	end

	// write pulse and data leave together on the strobe rise
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			wr_req <= 1'h0;
		else
			wr_req <= sel && wr_rise && phase == muxp_pkg::MUXP_DATA;
	end

	// byte taken from the synchronised lines, aligned with the strobe
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			wr_data <= muxp_pkg::BYTE_RST;
		else if (sel && wr_rise && phase == muxp_pkg::MUXP_DATA)
			wr_data <= s.ad;
	end

	// ==============================================================
	// checks
	// ==============================================================
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	chk_addr_capture: assert property (
		(sel && latch_rise) |=> reg_addr == $past(s_ad))
		else $error("address not captured on latch rise");
	chk_data_enter: assert property (
		(sel && latch_rise) |=> phase == muxp_pkg::MUXP_DATA ##1 data_phase)
		else $error("data phase not entered after latch rise");
	chk_read_start: assert property (
		(sel && rd_fall && phase == muxp_pkg::MUXP_DATA) |=> rd_req ##1 !rd_req)
		else $error("read request not a single pulse");
	chk_read_byte: assert property (
		rd_req |=> ad_out == $past(rd_data))
		else $error("fetched byte not held for host");
	chk_write_start: assert property (
		(sel && wr_fall && phase == muxp_pkg::MUXP_DATA) |=> wr_start)
		else $error("write start missing");
	chk_write_store: assert property (
		(sel && wr_rise && phase == muxp_pkg::MUXP_DATA) |=> wr_req && wr_data == $past(s_ad))
		else $error("write byte not stored on strobe rise");
	chk_select_gate: assert property (
		$past(s_cs_n) |-> !rd_req && !wr_req && !wr_start && !ad_oe)
		else $error("activity without chip select");
	chk_drive_window: assert property (
		ad_oe |-> $past(!s_cs_n && !s_rd_n))
		else $error("lines driven outside selected read");
	chk_drive_release: assert property (
		(s_rd_n || s_cs_n) |=> !ad_oe)
		else $error("lines not released after read");
	chk_no_write_drive: assert property (
		(!s_wr_n && s_rd_n) |=> !ad_oe)
		else $error("lines driven during write");
endmodule

// ===== verif/muxp_host_model.sv
// host processor model for the multiplexed address/data port
// assumes the bench resolves the shared lines and feeds them back on ad_wire
module muxp_host_model (
	input wire logic clk,
	input wire logic [muxp_pkg::AD_W-1:0] ad_wire,
	output logic cs_n,
	output logic address_latch_n,
	output logic read_strobe_n,
	output logic write_strobe_n,
	output logic [muxp_pkg::AD_W-1:0] host_ad
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==============================================================
	// idle pins
	// ==============================================================
	// strobes idle high until the first access
	initial
	begin
		cs_n = 1'h1;
		address_latch_n = 1'h1;
		read_strobe_n = 1'h1;
		write_strobe_n = 1'h1;
		host_ad = 8'h00;
	end
	// pins move only on falling edges; 6 clocks per strobe level beats the 3 needed
	task automatic wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic select_addr(input logic [muxp_pkg::AD_W-1:0] a);
		cs_n = 1'h0;
		address_latch_n = 1'h0;
		host_ad = a;
		wait_n(6);
		address_latch_n = 1'h1;
		wait_n(3);
		host_ad = ~a;
		wait_n(3);
	endtask
	// sample read byte at strobe rise
	task automatic read_byte(output logic [muxp_pkg::AD_W-1:0] d);
		read_strobe_n = 1'h0;
		wait_n(6);
		d = ad_wire;
		read_strobe_n = 1'h1;
		wait_n(6);
	endtask
	task automatic write_byte(input logic [muxp_pkg::AD_W-1:0] d);
		host_ad = d;
		wait_n(4);
		write_strobe_n = 1'h0;
		wait_n(6);
		write_strobe_n = 1'h1;
		wait_n(2);
		// released lines show the inverse, not a stale copy
		host_ad = ~d;
		wait_n(4);
	endtask
	task automatic deselect();
		cs_n = 1'h1;
		wait_n(6);
	endtask
	// select without latching, so no data phase opens
	task automatic select_only();
		cs_n = 1'h0;
		wait_n(6);
	endtask
endmodule

// ===== verif/muxp_port_test.sv
// self-checking bench for the multiplexed host register port
// assumes storage answers with a fixed function of the address
module muxp_port_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'h0;
	logic sys_rst = 1'h1;
	logic [7:0] ad_out, reg_addr, wr_data, host_ad, rd_data;
	logic ad_oe, rd_req, wr_start, wr_req, data_phase;
	logic cs_n, address_latch_n, read_strobe_n, write_strobe_n;
	wire logic [7:0] ad_wire = ad_oe ? ad_out : host_ad; // resolved shared lines
	int n_errors = 0;
	int check_count = 0;
	int n_rd, n_ws, n_wr, n_oe; // pulse and drive counters
	logic [7:0] got;
	// storage answers on the rd_req clock, pattern differs from address
	assign rd_data = reg_addr ^ 8'ha5;
	always #50 clk = ~clk;
	// ==============================================================
	// instances
	// ==============================================================
	muxp_port i_muxp_port (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n),
		.address_latch_n(address_latch_n), .read_strobe_n(read_strobe_n),
		.write_strobe_n(write_strobe_n), .ad_in(ad_wire), .ad_out(ad_out), .ad_oe(ad_oe),
		.reg_addr(reg_addr), .rd_req(rd_req), .rd_data(rd_data), .wr_start(wr_start),
		.wr_req(wr_req), .wr_data(wr_data), .data_phase(data_phase));
	muxp_host_model i_muxp_host_model (.clk(clk), .ad_wire(ad_wire), .cs_n(cs_n),
		.address_latch_n(address_latch_n), .read_strobe_n(read_strobe_n),
		.write_strobe_n(write_strobe_n), .host_ad(host_ad));
	// count pulses and driven cycles since the last clear
	always @(posedge clk)
	begin
		n_rd += (rd_req === 1'h1);
		n_ws += (wr_start === 1'h1);
		n_wr += (wr_req === 1'h1);
		n_oe += (ad_oe === 1'h1);
	end
	// ==============================================================
	// checking and closing
	// ==============================================================
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic clear();
		n_rd = 0;
		n_ws = 0;
		n_wr = 0;
		n_oe = 0;
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ==============================================================
	// scenarios
	// ==============================================================
	// write stores held byte
	task automatic t_write(input logic [7:0] a, input logic [7:0] d);
		clear();
		i_muxp_host_model.select_addr(a);
		check("data_phase", 32'(data_phase), 32'h1);
		i_muxp_host_model.write_byte(d);
		check("reg_addr", 32'(reg_addr), 32'(a));
		check("wr_data", 32'(wr_data), 32'(d));
		check("wr_start", 32'(n_ws), 32'h1);
		check("wr_req", 32'(n_wr), 32'h1);
		check("oe on write", 32'(n_oe), 32'h0);
		i_muxp_host_model.deselect();
		check("phase off", 32'(data_phase), 32'h0);
	endtask
	task automatic t_read(input logic [7:0] a);
		clear();
		i_muxp_host_model.select_addr(a);
		check("oe before", 32'(ad_oe), 32'h0);
		repeat (2)
		begin
			i_muxp_host_model.read_byte(got);
			check("read byte", 32'(got), 32'(a ^ 8'ha5));
		end
		check("rd_req", 32'(n_rd), 32'h2);
		check("oe cycles", 32'(n_oe), 32'hc);
		check("no write", 32'(n_ws + n_wr), 32'h0);
		i_muxp_host_model.deselect();
	endtask
	task automatic t_refused(input logic [7:0] a);
		clear();
		i_muxp_host_model.read_byte(got);
		i_muxp_host_model.write_byte(a);
		i_muxp_host_model.select_only();
		i_muxp_host_model.read_byte(got);
		i_muxp_host_model.write_byte(a);
		i_muxp_host_model.deselect();
		check("refused pulses", 32'(n_rd + n_ws + n_wr), 32'h0);
		check("refused oe", 32'(n_oe), 32'h0);
		check("addr kept", 32'(reg_addr), 32'h3c);
	endtask
	// ==============================================================
	// main sequence and watchdog
	// ==============================================================
	initial
	begin
		repeat (5) @(negedge clk);
		sys_rst = 1'h0;
		repeat (2) @(negedge clk);
		t_write(8'h00, 8'hff);
		t_write(8'hff, 8'h5a);
		t_read(8'h81);
		t_write(8'h3c, 8'h96);
		t_refused(8'h11);
		end_sim();
	end
	// whole run needs about 220 clocks
	initial
	begin
		repeat (5000) @(posedge clk);
		n_errors++;
		end_sim();
	end
endmodule
